// ### pkg/fdps_pkg.sv
// Constants and types for the flash data page sequencer
package fdps_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_PAGE_READ = 8'h01;
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] CMD_PAGE_VERIFY = 8'h04;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h05;
  localparam logic [7:0] CMD_WHOLE_ERASE = 8'h06;
  localparam logic [7:0] CMD_BYTE_READ = 8'h81;
  localparam logic [7:0] CMD_BYTE_WRITE = 8'h82;
  localparam logic [7:0] CMD_RESET_VAL = 8'h00;
  localparam logic [7:0] VERIFY_OK = 8'h00;

  // ==========================================================
  // Array geometry
  localparam int unsigned PAGE_BYTES = 4;
  localparam int unsigned DATA_BYTES = 4096;
  localparam int unsigned PAGES = DATA_BYTES / PAGE_BYTES;
  localparam int unsigned PAGE_AW = 10;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [31:0] ERASED_PAGE = 32'hffffffff;
  localparam int unsigned USER_LOADER_MODE_WRITE_BYTES = 256;
  localparam int unsigned USER_LOADER_MODE_ERASE_BYTES = 64;

  // ==========================================================
  // Program array partition
  localparam logic [4:0] HIDDEN_TOP = 5'h1f;
  localparam int unsigned HIDDEN_LSB = 11;

  // ==========================================================
  // Parallel programming mode codes
  localparam logic [3:0] PAR_ERASE_ALL = 4'h0;
  localparam logic [3:0] PAR_PROG_CODE = 4'ha;
  localparam logic [3:0] PAR_PROG_DATA = 4'h2;
  localparam logic [3:0] PAR_READ_CODE = 4'hb;
  localparam logic [3:0] PAR_READ_DATA = 4'h3;
  localparam logic [3:0] PAR_PROG_SEC = 4'hc;
  localparam logic [3:0] PAR_READ_SEC = 4'hd;

  typedef enum logic [2:0] {
    FDPS_PAR_NONE, FDPS_PAR_ERASE_ALL, FDPS_PAR_PROG_CODE, FDPS_PAR_PROG_DATA,
    FDPS_PAR_READ_CODE, FDPS_PAR_READ_DATA, FDPS_PAR_PROG_SEC, FDPS_PAR_READ_SEC
  } fdps_par_op_t;

  typedef enum logic [1:0] {FDPS_PROG_NONE, FDPS_PROG_WRITE, FDPS_PROG_ERASE} fdps_prog_op_t;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned MACH_CLKS = 1;
  localparam int unsigned T_PAGE_READ_MC = 25;
  localparam int unsigned T_BYTE_READ_MC = 10;
  localparam int unsigned T_PAGE_WRITE_US = 380;
  localparam int unsigned T_BYTE_WRITE_US = 200;
  localparam int unsigned T_ERASE_MS = 2;
  localparam int unsigned T_USER_LOADER_MODE_WRITE_MS = 15;
  localparam int unsigned C_PAGE_READ = T_PAGE_READ_MC * MACH_CLKS;
  localparam int unsigned C_BYTE_READ = T_BYTE_READ_MC * MACH_CLKS;
  localparam int unsigned C_PAGE_WRITE = T_PAGE_WRITE_US * CLK_MHZ;
  localparam int unsigned C_BYTE_WRITE = T_BYTE_WRITE_US * CLK_MHZ;
  localparam int unsigned C_ERASE = T_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned C_USER_LOADER_MODE_WRITE = T_USER_LOADER_MODE_WRITE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 22;

endpackage : fdps_pkg

// ### verilog/fdps_sequencer.sv
// Flash data page sequencer: command timing, data array, partition and pin decode
// Function
// - Read-page copies addressed page into data regs
// - Codes 5/2/4 erase, program, verify page
// - Command 06H erases whole 4-kbyte array
// - Erase always covers whole 4-byte pages
// - Operation starts at once; core held idle
// - Interrupts held off; timers keep counting
// - Data array operation durations as listed
// - Loader mode program page write/erase timing
// - Lower 62 kbytes user, one block
// - Hidden upper 2 kbytes read as zero
// - Strobe pin low at reset enters download
// - Parallel pins carry address, data, strobe
// - Port 1 mode codes select parallel operation
// - 4-kbyte byte-programmable page-erased data space
`timescale 1ns/1ps
`default_nettype none
module fdps_sequencer #(
  parameter int unsigned PAGE_WRITE_CLKS = fdps_pkg::C_PAGE_WRITE,
  parameter int unsigned BYTE_WRITE_CLKS = fdps_pkg::C_BYTE_WRITE,
  parameter int unsigned ERASE_CLKS = fdps_pkg::C_ERASE,
  parameter int unsigned USER_LOADER_MODE_WRITE_CLKS = fdps_pkg::C_USER_LOADER_MODE_WRITE
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Core command side
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_flash_command_reg,
  input wire logic [7:0] i_page_addr_high,
  input wire logic [7:0] i_page_addr_low,
  input wire logic [1:0] i_byte_sel,
  input wire logic [31:0] i_page_data_regs,
  input wire logic i_user_loader_mode,
  output logic [31:0] o_page_data_regs,
  output logic [7:0] o_flash_command_reg,
  output logic o_core_stall,
  output logic o_irq_hold,
  output logic [1:0] o_prog_op,
  // Program array read path
  input wire logic [15:0] i_code_addr,
  input wire logic [7:0] i_code_rdata,
  output logic [7:0] o_code_data,
  // Pins
  input wire logic i_code_fetch_strobe_pin_n,
  input wire logic [15:0] i_par_addr,
  input wire logic [7:0] i_par_data,
  input wire logic i_par_wr_strobe,
  input wire logic [3:0] i_par_mode,
  output logic o_download_mode,
  output logic [2:0] o_par_op,
  output logic [15:0] o_par_addr,
  output logic [7:0] o_par_data,
  output logic o_par_strobe
);
  localparam int unsigned CW = fdps_pkg::CNT_W;
  localparam int unsigned AW = fdps_pkg::PAGE_AW;

  initial begin
    if (USER_LOADER_MODE_WRITE_CLKS >= (1 << CW) || ERASE_CLKS >= (1 << CW) || PAGE_WRITE_CLKS < 1
        || BYTE_WRITE_CLKS < 1 || ERASE_CLKS < 1 || USER_LOADER_MODE_WRITE_CLKS < 1) begin
      $error("fdps_sequencer: duration parameter out of range");
    end
  end

  // ==========================================================
  // Command sequencer
  typedef enum logic {FDPS_IDLE, FDPS_BUSY} fdps_state_t;
  fdps_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [7:0] cmd_q, cmd_d;
  logic [31:0] edata_q, edata_d;
  logic stall_q, stall_d;
  logic [1:0] prog_q, prog_d;
  logic [fdps_pkg::PAGE_AW-1:0] page_q, page_d;
  logic [1:0] bsel_q, bsel_d;
  logic user_loader_mode_q, user_loader_mode_d;
  logic [31:0] mem_q [fdps_pkg::PAGES];
  logic [31:0] mem_d [fdps_pkg::PAGES];

  function automatic logic [CW-1:0] dur(input logic [7:0] c, input logic ul);
    logic [CW-1:0] r;
    r = '0;
    unique case (c)
      fdps_pkg::CMD_PAGE_READ, fdps_pkg::CMD_PAGE_VERIFY:
        r = CW'(fdps_pkg::C_PAGE_READ - 1);
      fdps_pkg::CMD_BYTE_READ: r = CW'(fdps_pkg::C_BYTE_READ - 1);
      fdps_pkg::CMD_PAGE_WRITE:
        r = ul ? CW'(USER_LOADER_MODE_WRITE_CLKS - 1) : CW'(PAGE_WRITE_CLKS - 1);
      fdps_pkg::CMD_BYTE_WRITE: r = CW'(BYTE_WRITE_CLKS - 1);
      default: r = CW'(ERASE_CLKS - 1);
    endcase
    return r;
  endfunction : dur

  function automatic logic known(input logic [7:0] c);
    return c == fdps_pkg::CMD_PAGE_READ || c == fdps_pkg::CMD_PAGE_WRITE
      || c == fdps_pkg::CMD_PAGE_VERIFY || c == fdps_pkg::CMD_PAGE_ERASE
      || c == fdps_pkg::CMD_WHOLE_ERASE || c == fdps_pkg::CMD_BYTE_READ
      || c == fdps_pkg::CMD_BYTE_WRITE;
  endfunction : known

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    edata_d = i_cmd_wr ? i_page_data_regs : edata_q;
    stall_d = stall_q;
    prog_d = prog_q;
    page_d = page_q;
    bsel_d = bsel_q;
    user_loader_mode_d = user_loader_mode_q;
    mem_d = mem_q;
    unique case (state_q)
      FDPS_IDLE: begin
        if (i_cmd_wr) begin
          cmd_d = i_flash_command_reg;
          if (known(i_flash_command_reg)) begin
            state_d = FDPS_BUSY;
            stall_d = 1'b1;
            cnt_d = dur(i_flash_command_reg, i_user_loader_mode);
            page_d = AW'({i_page_addr_high, i_page_addr_low});
            bsel_d = i_byte_sel;
            user_loader_mode_d = i_user_loader_mode;
            if (i_user_loader_mode && i_flash_command_reg == fdps_pkg::CMD_PAGE_WRITE) begin
              prog_d = fdps_pkg::FDPS_PROG_WRITE;
            end else if (i_user_loader_mode && i_flash_command_reg == fdps_pkg::CMD_PAGE_ERASE) begin
              prog_d = fdps_pkg::FDPS_PROG_ERASE;
            end
          end
        end
      end
      FDPS_BUSY: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - CW'(1);
        end else begin
          state_d = FDPS_IDLE;
          stall_d = 1'b0;
          prog_d = fdps_pkg::FDPS_PROG_NONE;
          if (!user_loader_mode_q) begin
            unique case (cmd_q)
              fdps_pkg::CMD_PAGE_READ: edata_d = mem_q[page_q];
              fdps_pkg::CMD_PAGE_ERASE: mem_d[page_q] = fdps_pkg::ERASED_PAGE;
              fdps_pkg::CMD_PAGE_WRITE: mem_d[page_q] = mem_q[page_q] & edata_q;
              fdps_pkg::CMD_PAGE_VERIFY: begin
                if (mem_q[page_q] == edata_q) begin
                  cmd_d = fdps_pkg::VERIFY_OK;
                end
              end
              fdps_pkg::CMD_WHOLE_ERASE: begin
                for (int i = 0; i < fdps_pkg::PAGES; i++) begin
                  mem_d[i] = fdps_pkg::ERASED_PAGE;
                end
              end
              fdps_pkg::CMD_BYTE_READ: edata_d[8*bsel_q +: 8] = mem_q[page_q][8*bsel_q +: 8];
              fdps_pkg::CMD_BYTE_WRITE:
                mem_d[page_q][8*bsel_q +: 8] = mem_q[page_q][8*bsel_q +: 8]
                  & edata_q[8*bsel_q +: 8];
              default: begin
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= FDPS_IDLE;
      cnt_q <= '0;
      cmd_q <= fdps_pkg::CMD_RESET_VAL;
      edata_q <= '0;
      stall_q <= 1'b0;
      prog_q <= fdps_pkg::FDPS_PROG_NONE;
      page_q <= '0;
      bsel_q <= '0;
      user_loader_mode_q <= 1'b0;
      for (int i = 0; i < fdps_pkg::PAGES; i++) begin
        mem_q[i] <= fdps_pkg::ERASED_PAGE;
      end
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      edata_q <= edata_d;
      stall_q <= stall_d;
      prog_q <= prog_d;
      page_q <= page_d;
      bsel_q <= bsel_d;
      user_loader_mode_q <= user_loader_mode_d;
      mem_q <= mem_d;
    end
  end

  assign o_page_data_regs = edata_q;
  assign o_flash_command_reg = cmd_q;
  assign o_core_stall = stall_q;
  assign o_irq_hold = stall_q;
  assign o_prog_op = prog_q;

  // ==========================================================
  // Pin synchronisers, strap, program array read, parallel decode
  logic [29:0] sy1_q, sy2_q, sy1_d, sy2_d;
  logic strap_q, strap_d, armed_q, armed_d, strb_q, strb_d;
  logic arm1_q, arm1_d, arm2_q, arm2_d;
  logic [7:0] code_q, code_d;
  logic [2:0] pop_q, pop_d;
  logic [15:0] paddr_q, paddr_d;
  logic [7:0] pdata_q, pdata_d;

  always_comb begin
    sy1_d = {i_code_fetch_strobe_pin_n, i_par_wr_strobe, i_par_mode, i_par_addr, i_par_data};
    sy2_d = sy1_q;
    arm1_d = 1'b1;
    arm2_d = arm1_q;
    armed_d = arm2_q;
    strap_d = armed_q ? strap_q : !sy2_q[29];
    code_d = (i_code_addr[15:fdps_pkg::HIDDEN_LSB] == fdps_pkg::HIDDEN_TOP)
      ? 8'h00 : i_code_rdata;
    strb_d = sy2_q[28];
    paddr_d = sy2_q[23:8];
    pdata_d = sy2_q[7:0];
    unique case (sy2_q[27:24])
      fdps_pkg::PAR_ERASE_ALL: pop_d = fdps_pkg::FDPS_PAR_ERASE_ALL;
      fdps_pkg::PAR_PROG_CODE: pop_d = fdps_pkg::FDPS_PAR_PROG_CODE;
      fdps_pkg::PAR_PROG_DATA: pop_d = fdps_pkg::FDPS_PAR_PROG_DATA;
      fdps_pkg::PAR_READ_CODE: pop_d = fdps_pkg::FDPS_PAR_READ_CODE;
      fdps_pkg::PAR_READ_DATA: pop_d = fdps_pkg::FDPS_PAR_READ_DATA;
      fdps_pkg::PAR_PROG_SEC: pop_d = fdps_pkg::FDPS_PAR_PROG_SEC;
      fdps_pkg::PAR_READ_SEC: pop_d = fdps_pkg::FDPS_PAR_READ_SEC;
      default: pop_d = fdps_pkg::FDPS_PAR_NONE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sy1_q <= 30'h20000000;
      sy2_q <= 30'h20000000;
      strap_q <= 1'b0;
      armed_q <= 1'b0;
      arm1_q <= 1'b0;
      arm2_q <= 1'b0;
      code_q <= '0;
      strb_q <= 1'b0;
      pop_q <= fdps_pkg::FDPS_PAR_NONE;
      paddr_q <= '0;
      pdata_q <= '0;
    end else begin
      sy1_q <= sy1_d;
      sy2_q <= sy2_d;
      strap_q <= strap_d;
      armed_q <= armed_d;
      arm1_q <= arm1_d;
      arm2_q <= arm2_d;
      code_q <= code_d;
      strb_q <= strb_d;
      pop_q <= pop_d;
      paddr_q <= paddr_d;
      pdata_q <= pdata_d;
    end
  end

  assign o_download_mode = strap_q;
  assign o_code_data = code_q;
  assign o_par_op = pop_q;
  assign o_par_addr = paddr_q;
  assign o_par_data = pdata_q;
  assign o_par_strobe = strb_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_stall_start;
    state_q == FDPS_IDLE && i_cmd_wr && known(i_flash_command_reg) |=> o_core_stall;
  endproperty
  a_stall_start: assert property (p_stall_start) else $error("no stall after command");

  property p_read_len;
    state_q == FDPS_IDLE && i_cmd_wr && i_flash_command_reg == fdps_pkg::CMD_PAGE_READ
      |=> o_core_stall [*8] ##18 !o_core_stall;
  endproperty
  a_read_len: assert property (p_read_len) else $error("page read length wrong");

  property p_read_copy;
    state_q == FDPS_BUSY && cnt_q == '0 && cmd_q == fdps_pkg::CMD_PAGE_READ && !user_loader_mode_q
      |=> o_page_data_regs == $past(mem_q[page_q]);
  endproperty
  a_read_copy: assert property (p_read_copy) else $error("page read copy wrong");

  property p_erase;
    state_q == FDPS_BUSY && cnt_q == '0 && cmd_q == fdps_pkg::CMD_PAGE_ERASE && !user_loader_mode_q
      |=> mem_q[$past(page_q)] == fdps_pkg::ERASED_PAGE;
  endproperty
  a_erase: assert property (p_erase) else $error("page not erased");

  property p_whole;
    state_q == FDPS_BUSY && cnt_q == '0 && cmd_q == fdps_pkg::CMD_WHOLE_ERASE && !user_loader_mode_q
      |=> mem_q[0] == fdps_pkg::ERASED_PAGE && mem_q[fdps_pkg::PAGES-1] == fdps_pkg::ERASED_PAGE;
  endproperty
  a_whole: assert property (p_whole) else $error("array not erased");

  property p_verify;
    state_q == FDPS_BUSY && cnt_q == '0 && cmd_q == fdps_pkg::CMD_PAGE_VERIFY && !user_loader_mode_q
      && mem_q[page_q] == edata_q |=> o_flash_command_reg == fdps_pkg::VERIFY_OK && !o_core_stall;
  endproperty
  a_verify: assert property (p_verify) else $error("verify result wrong");

  property p_hidden;
    i_code_addr[15:fdps_pkg::HIDDEN_LSB] == fdps_pkg::HIDDEN_TOP |=> o_code_data == 8'h00;
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden region visible");

  property p_par_prog;
    sy2_q[27:24] == fdps_pkg::PAR_PROG_DATA |=> o_par_op == fdps_pkg::FDPS_PAR_PROG_DATA;
  endproperty
  a_par_prog: assert property (p_par_prog) else $error("parallel decode wrong");

  property p_strap_hold;
    armed_q |=> $stable(o_download_mode);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

endmodule : fdps_sequencer
`default_nettype wire

// ### tb/fdps_code_mem.sv
// Program array model answering same-clock code fetches
`timescale 1ns/1ps
`default_nettype none
module fdps_code_mem (
  // Fetch side
  input wire logic [15:0] i_addr,
  output logic [7:0] o_rdata
);
  // Never zero, so a blanked fetch stands out
  assign o_rdata = (i_addr[7:0] ^ i_addr[15:8] ^ 8'h5a) | 8'h01;
endmodule : fdps_code_mem
`default_nettype wire

// ### tb/fdps_sequencer_tb_top.sv
// Self-checking bench for the flash data page sequencer
`timescale 1ns/1ps
`default_nettype none
module fdps_sequencer_tb_top;
  typedef struct {logic [7:0] c; logic [9:0] p; logic [31:0] d; int n;
    logic [31:0] e; logic k; logic [7:0] q;} fdps_row_t;
  // ==========================================================
  // Signals
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic cmd_wr = 1'b0, user_loader_mode = 1'b0, strap_n = 1'b0, par_wr = 1'b0;
  logic [7:0] code = 8'h00, par_data = 8'h00, code_rdata, cmdq, code_data, par_data_q;
  logic [9:0] page = 10'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] code_addr = 16'h0000, par_addr = 16'h0000, par_addr_q;
  logic [3:0] par_mode = 4'h0;
  logic [2:0] par_op;
  logic [1:0] prog_op, first_op;
  logic stall, irqh, dl, par_stb;
  int num_errors = 0, checked = 0, n;
  fdps_row_t rows[13] = '{
    '{8'h06, 10'h000, 32'h0, 60, 32'h0, 1'b0, 8'h06},
    '{8'h01, 10'h003, 32'h0, 25, 32'hffffffff, 1'b1, 8'h01},
    '{8'h02, 10'h003, 32'h12f3ab00, 40, 32'h0, 1'b0, 8'h02},
    '{8'h01, 10'h003, 32'h0, 25, 32'h12f3ab00, 1'b1, 8'h01},
    '{8'h04, 10'h003, 32'h12f3ab00, 25, 32'h0, 1'b0, 8'h00},
    '{8'h02, 10'h004, 32'h0, 40, 32'h0, 1'b0, 8'h02},
    '{8'h05, 10'h003, 32'h0, 60, 32'h0, 1'b0, 8'h05},
    '{8'h01, 10'h004, 32'hffffffff, 25, 32'h0, 1'b1, 8'h01},
    '{8'h01, 10'h003, 32'h0, 25, 32'hffffffff, 1'b1, 8'h01},
    '{8'h81, 10'h003, 32'h0, 10, 32'h0, 1'b0, 8'h81},
    '{8'h82, 10'h003, 32'h0, 20, 32'h0, 1'b0, 8'h82},
    '{8'h06, 10'h000, 32'h0, 60, 32'h0, 1'b0, 8'h06},
    '{8'h01, 10'h004, 32'h0, 25, 32'hffffffff, 1'b1, 8'h01}
  };
  logic [15:0] addrs[4] = '{16'hf7ff, 16'hf800, 16'hffff, 16'h0123};
  logic [7:0] ecd;
  always #2.5 i_clock = ~i_clock;
  // ==========================================================
  // Design and partner
  fdps_sequencer #(.PAGE_WRITE_CLKS(40), .BYTE_WRITE_CLKS(20), .ERASE_CLKS(60),
    .USER_LOADER_MODE_WRITE_CLKS(80)) fdps_sequencer_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_cmd_wr(cmd_wr), .i_flash_command_reg(code), .i_page_addr_high({6'h00, page[9:8]}),
    .i_page_addr_low(page[7:0]), .i_byte_sel(2'h0), .i_page_data_regs(wdata),
    .i_user_loader_mode(user_loader_mode), .o_page_data_regs(rdata), .o_flash_command_reg(cmdq),
    .o_core_stall(stall), .o_irq_hold(irqh), .o_prog_op(prog_op), .i_code_addr(code_addr),
    .i_code_rdata(code_rdata), .o_code_data(code_data), .i_code_fetch_strobe_pin_n(strap_n),
    .i_par_addr(par_addr), .i_par_data(par_data), .i_par_wr_strobe(par_wr),
    .i_par_mode(par_mode), .o_download_mode(dl), .o_par_op(par_op), .o_par_addr(par_addr_q),
    .o_par_data(par_data_q), .o_par_strobe(par_stb));
  fdps_code_mem fdps_code_mem_inst (.i_addr(code_addr), .o_rdata(code_rdata));
  // ==========================================================
  // Tasks
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic issue(input logic [7:0] c, input logic [9:0] p, input logic [31:0] d);
    @(negedge i_clock);
    code = c;
    page = p;
    wdata = d;
    cmd_wr = 1'b1;
    @(negedge i_clock);
    cmd_wr = 1'b0;
  endtask : issue
  task automatic run(input logic [7:0] c, input logic [9:0] p, input logic [31:0] d,
      output int cnt);
    issue(c, p, d);
    cnt = 0;
    first_op = prog_op;
    while (stall === 1'b1 && cnt < 2000) begin
      check(irqh === 1'b1, "interrupts not held while busy");
      cnt++;
      @(negedge i_clock);
    end
  endtask : run
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  function automatic logic [2:0] par_exp(input logic [3:0] m);
    case (m)
      4'h0: return 3'h1;
      4'ha: return 3'h2;
      4'h2: return 3'h3;
      4'hb: return 3'h4;
      4'h3: return 3'h5;
      4'hc: return 3'h6;
      4'hd: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction : par_exp
  // ==========================================================
  // Watchdog
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(negedge i_clock);
    check(stall === 1'b0 && cmdq === 8'h00 && rdata === 32'h0, "reset values");
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clock);
    check(dl === 1'b1, "download strap");
    strap_n = 1'b1;
    foreach (rows[i]) begin
      run(rows[i].c, rows[i].p, rows[i].d, n);
      check(n == rows[i].n, $sformatf("row %0d busy %0d", i, n));
      check(cmdq === rows[i].q, $sformatf("row %0d command reg", i));
      if (rows[i].k) check(rdata === rows[i].e, $sformatf("row %0d data", i));
    end
    run(8'h02, 10'h005, 32'h0, n);
    issue(8'h01, 10'h005, 32'h0);
    issue(8'h06, 10'h000, 32'h0);
    repeat (30) @(negedge i_clock);
    check(cmdq === 8'h01 && stall === 1'b0, "busy write not ignored");
    run(8'h01, 10'h005, 32'h0, n);
    check(rdata === 32'h0, "ignored erase acted");
    run(8'h33, 10'h005, 32'h0, n);
    check(n == 0 && cmdq === 8'h33, "unknown code");
    run(8'h04, 10'h005, 32'hffffffff, n);
    check(cmdq === 8'h04, "verify failure");
    user_loader_mode = 1'b1;
    run(8'h02, 10'h006, 32'h0, n);
    check(n == 80 && first_op === 2'h1, "loader page write");
    run(8'h05, 10'h006, 32'h0, n);
    check(n == 60 && first_op === 2'h2, "loader page erase");
    user_loader_mode = 1'b0;
    run(8'h01, 10'h006, 32'h0, n);
    check(rdata === 32'hffffffff, "loader touched data array");
    foreach (addrs[i]) begin
      code_addr = addrs[i];
      ecd = (addrs[i][7:0] ^ addrs[i][15:8] ^ 8'h5a) | 8'h01;
      @(negedge i_clock);
      if (addrs[i][15:11] == 5'h1f) ecd = 8'h00;
      check(code_data === ecd, "code fetch");
    end
    for (int m = 0; m < 16; m++) begin
      par_mode = m[3:0];
      par_addr = {m[3:0], 12'h5a3};
      par_data = {m[3:0], 4'hc};
      par_wr = m[0];
      repeat (4) @(negedge i_clock);
      check(par_op === par_exp(m[3:0]), $sformatf("mode %0d", m));
      check(par_addr_q === par_addr && par_data_q === par_data && par_stb === par_wr,
        "parallel pins");
    end
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clock);
    check(stall === 1'b0 && cmdq === 8'h00 && dl === 1'b0, "mid-run reset values");
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    check(dl === 1'b0, "download without strap");
    end_sim();
  end
endmodule : fdps_sequencer_tb_top
`default_nettype wire
